// ---- spf_pkg.sv ----
// Constants, field layouts and state types for the four-mode serial port
package spf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses (IRQ pair shared; others port 0, each further port adds PORT_STRIDE)
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h80;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h84;
  localparam logic [7:0] ADDR_SCTL     = 8'h98;
  localparam logic [7:0] ADDR_SDATA    = 8'h9c;
  localparam logic [7:0] ADDR_CFG      = 8'ha0;
  localparam logic [7:0] PORT_STRIDE   = 8'h40;

  ////////////////////////////////////////////////////////////////////////////
  // serial_control bit positions and reset value
  localparam int SC_MODE_HI = 7;
  localparam int SC_MODE_LO = 6;
  localparam int SC_MP      = 5;
  localparam int SC_REN     = 4;
  localparam int SC_TB9     = 3;
  localparam int SC_RB9     = 2;
  localparam int SC_TI      = 1;
  localparam int SC_RI      = 0;
  localparam logic [7:0] SCTL_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Port configuration word: divisor, given and broadcast address, selects
  localparam int CFG_DIV_LSB   = 0;
  localparam int CFG_GIVEN_LSB = 8;
  localparam int CFG_BCAST_LSB = 16;
  localparam int CFG_FES       = 24;
  localparam int CFG_SWAP      = 25;
  localparam logic [31:0] CFG_RESET = 32'h00ff000c;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status layout, per port
  localparam int STAT_TX = 0;
  localparam int STAT_RX = 1;
  localparam int STAT_FE = 2;
  localparam int STAT_W  = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: shift clock ratios and 16x oversampling
  localparam int M0_DIV_SLOW  = 12;
  localparam int M0_DIV_FAST  = 2;
  localparam int MODE2_OS_DIV = 2;
  localparam logic [3:0] OS_MID  = 4'h7;
  localparam logic [3:0] OS_LAST = 4'hf;

  ////////////////////////////////////////////////////////////////////////////
  // Modes and states
  typedef enum logic [1:0] {
    MODE_SHIFT = 2'b00,
    MODE_8VAR  = 2'b01,
    MODE_9FIX  = 2'b10,
    MODE_9VAR  = 2'b11
  } spf_mode_e;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_START = 2'b01,
    TX_DATA  = 2'b10,
    TX_STOP  = 2'b11
  } spf_tx_e;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } spf_rx_e;

  typedef enum logic [1:0] {
    M0_IDLE = 2'b00,
    M0_TX   = 2'b01,
    M0_RX   = 2'b10
  } spf_m0_e;

endpackage : spf_pkg

// ---- spf_remote.sv ----
// Remote transceiver on the first port's serial lines
`timescale 1ns/1ns
module spf_remote #(
  parameter int BIT = 16
) (
  // Clock and lines
  input wire logic   ref_clk,
  input wire logic   tx_line,
  output logic       rx_line = 1'b1,
  // Decoded frame: ninth bit (stop bit in mode 1) over data
  output logic [8:0] got = '0,
  output logic       got_v = 1'b0
);
  // Start, eight bits LSB first, stop; mark afterwards
  task automatic send(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_line <= f[i];
      repeat (BIT) @(posedge ref_clk);
    end
    rx_line <= 1'b1;
  endtask : send
  initial forever begin
    @(negedge tx_line);
    repeat (BIT / 2) @(posedge ref_clk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT) @(posedge ref_clk);
      got[i] <= tx_line;
    end
    got_v <= 1'b1;
    @(posedge ref_clk);
    got_v <= 1'b0;
  end
endmodule : spf_remote

// ---- spf_top.sv ----
// Four-mode serial port: per-port engine and APB top with interrupts
//
// Overview of operation
// - One synchronous shift mode 0 and three asynchronous full-duplex modes.
// - Asynchronous transmitter and receiver run independently of each other.
// - In modes 1-3 the receiver keeps shifting a new byte while the previous one is unread.
// - One data address: writes load transmit, reads return separate receive.
// - Any write to the data buffer starts transmitting it, in every mode.
// - Pin swap select exchanges transmit and receive pins of the first port.
// - With frame error select set, control bit 7 is a sticky framing flag.
// - Mode 0 shift clock is system clock /12, or /2 with multiproc bit.
// - Mode 1 with multiproc bit: accept only stop=1 and address match.
// - Modes 2,3 with multiproc bit: accept only ninth=1 and address match.
// - Receive enable gates reception; mode 0 starts with enable=1, done=0.
// - Modes 2,3 send the transmit ninth bit; modes 0,1 ignore it.
// - Received ninth bit takes ninth bit or mode 1 stop, when accepted.
// - Transmit done sets after eighth bit or last data bit; software clears.
// - Receive done sets after eighth bit or accepted stop; software clears.
// - Enabled transmit or receive done raises the interrupt request.
// - Two identical port instances, each with own registers and pins.
`timescale 1ns/1ns

module spf_port (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // Register access
  input  wire logic        wr_sctl,
  input  wire logic        wr_sdata,
  input  wire logic        wr_cfg,
  input  wire logic [31:0] wdata,
  output logic      [7:0]  sctl_rd,
  output logic      [7:0]  sdata_rd,
  output logic      [31:0] cfg_rd,
  output logic             pin_swap_select,
  // Serial lines, in the transmit-pin and receive-pin roles
  input  wire logic        rxd_in,
  output logic             txr_out,
  output logic             rxr_out,
  output logic             rxr_oe_n,
  // Event pulses
  output logic             ev_tx,
  output logic             ev_rx,
  output logic             ev_fe
);

  logic mode_hi_q, mode_lo_q, multiproc_enable_q, rx_enable_q;
  logic tx_ninth_bit_q, rx_ninth_bit_q;
  logic tx_done_flag_q, rx_done_flag_q, framing_error_flag_q;
  logic [31:0] cfg_q;
  logic [7:0]  rx_hold_q;
  spf_pkg::spf_mode_e mode;
  logic        fes, nine;

  assign mode = spf_pkg::spf_mode_e'({mode_hi_q, mode_lo_q});
  assign fes  = cfg_q[spf_pkg::CFG_FES];
  assign nine = mode_hi_q;

  ////////////////////////////////////////////////////////////////////////////
  // Oversampling tick for the asynchronous modes
  logic [7:0] baud_cnt_q;
  logic [7:0] os_per_m1;
  logic       tick;

  assign os_per_m1 = (mode == spf_pkg::MODE_9FIX) ?
                     8'(spf_pkg::MODE2_OS_DIV - 1) :
                     cfg_q[spf_pkg::CFG_DIV_LSB +: 8];
  assign tick = (baud_cnt_q >= os_per_m1);

  always_ff @(posedge ref_clk) begin
    if (reset || tick) begin
      baud_cnt_q <= 8'h00;
    end else begin
      baud_cnt_q <= baud_cnt_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Asynchronous transmitter
  spf_pkg::spf_tx_e tx_st_q;
  logic [8:0] tx_sh_q;
  logic [3:0] tx_bit_q, tx_os_q, bit_last;
  logic       tx_line_q, tx_fin;

  assign bit_last = nine ? 4'h8 : 4'h7;
  assign tx_fin   = tick && (tx_st_q == spf_pkg::TX_DATA) &&
                    (tx_os_q == spf_pkg::OS_LAST) && (tx_bit_q == bit_last);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tx_st_q   <= spf_pkg::TX_IDLE;
      tx_sh_q   <= 9'h000;
      tx_bit_q  <= 4'h0;
      tx_os_q   <= 4'h0;
      tx_line_q <= 1'b1;
    end else if (wr_sdata && mode != spf_pkg::MODE_SHIFT) begin
      tx_st_q   <= spf_pkg::TX_START;
      tx_sh_q   <= {(nine ? tx_ninth_bit_q : 1'b1), wdata[7:0]};
      tx_bit_q  <= 4'h0;
      tx_os_q   <= 4'h0;
      tx_line_q <= 1'b0;
    end else if (tick && tx_st_q != spf_pkg::TX_IDLE) begin
      tx_os_q <= tx_os_q + 4'h1;
      if (tx_os_q == spf_pkg::OS_LAST) begin
        case (tx_st_q)
          spf_pkg::TX_START: begin
            tx_st_q   <= spf_pkg::TX_DATA;
            tx_line_q <= tx_sh_q[0];
            tx_sh_q   <= {1'b1, tx_sh_q[8:1]};
          end
          spf_pkg::TX_DATA: begin
            if (tx_bit_q == bit_last) begin
              tx_st_q   <= spf_pkg::TX_STOP;
              tx_line_q <= 1'b1;
            end else begin
              tx_bit_q  <= tx_bit_q + 4'h1;
              tx_line_q <= tx_sh_q[0];
              tx_sh_q   <= {1'b1, tx_sh_q[8:1]};
            end
          end
          spf_pkg::TX_STOP: tx_st_q <= spf_pkg::TX_IDLE;
          default:          tx_st_q <= spf_pkg::TX_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Asynchronous receiver, independent of the transmitter
  spf_pkg::spf_rx_e rx_st_q;
  logic [8:0] rx_sh_q;
  logic [3:0] rx_bit_q, rx_os_q;
  logic       rx_prev_q, rx_fin;

  assign rx_fin = tick && (rx_st_q == spf_pkg::RX_STOP) &&
                  (rx_os_q == spf_pkg::OS_LAST);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rx_prev_q <= 1'b1;
    end else begin
      rx_prev_q <= rxd_in;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rx_st_q  <= spf_pkg::RX_IDLE;
      rx_sh_q  <= 9'h000;
      rx_bit_q <= 4'h0;
      rx_os_q  <= 4'h0;
    end else if (!rx_enable_q || mode == spf_pkg::MODE_SHIFT) begin
      rx_st_q <= spf_pkg::RX_IDLE;
    end else if (rx_st_q == spf_pkg::RX_IDLE) begin
      if (rx_prev_q && !rxd_in) begin
        rx_st_q <= spf_pkg::RX_START;
        rx_os_q <= 4'h0;
      end
    end else if (tick) begin
      rx_os_q <= rx_os_q + 4'h1;
      case (rx_st_q)
        spf_pkg::RX_START: begin
          if (rx_os_q == spf_pkg::OS_MID) begin
            rx_st_q  <= rxd_in ? spf_pkg::RX_IDLE : spf_pkg::RX_DATA;
            rx_os_q  <= 4'h0;
            rx_bit_q <= 4'h0;
          end
        end
        spf_pkg::RX_DATA: begin
          if (rx_os_q == spf_pkg::OS_LAST) begin
            rx_sh_q <= {rxd_in, rx_sh_q[8:1]};
            if (rx_bit_q == bit_last) begin
              rx_st_q <= spf_pkg::RX_STOP;
            end else begin
              rx_bit_q <= rx_bit_q + 4'h1;
            end
          end
        end
        spf_pkg::RX_STOP: begin
          if (rx_os_q == spf_pkg::OS_LAST) begin
            rx_st_q <= spf_pkg::RX_IDLE;
          end
        end
        default: rx_st_q <= spf_pkg::RX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acceptance filter for a finished asynchronous frame
  logic [7:0] rx_data;
  logic       rx_ninth, addr_match, accept_ok, rx_load_async;

  assign rx_data    = nine ? rx_sh_q[7:0] : rx_sh_q[8:1];
  assign rx_ninth   = nine ? rx_sh_q[8] : rxd_in;
  assign addr_match = (rx_data == cfg_q[spf_pkg::CFG_GIVEN_LSB +: 8]) ||
                      (rx_data == cfg_q[spf_pkg::CFG_BCAST_LSB +: 8]);
  assign accept_ok  = !multiproc_enable_q || (rx_ninth && addr_match);
  assign rx_load_async = rx_fin && accept_ok && !rx_done_flag_q;

  ////////////////////////////////////////////////////////////////////////////
  // Mode 0 shift engine: data on the receive pin, clock on the transmit pin
  spf_pkg::spf_m0_e m0_st_q;
  logic [7:0] m0_sh_q, m0_cnt_q, half_m1;
  logic [2:0] m0_bit_q;
  logic       m0_clk_q, m0_step, m0_fin, m0_rx_start;

  assign half_m1 = multiproc_enable_q ? 8'(spf_pkg::M0_DIV_FAST / 2 - 1) :
                                        8'(spf_pkg::M0_DIV_SLOW / 2 - 1);
  assign m0_step = (m0_cnt_q == half_m1);
  assign m0_fin  = (m0_st_q != spf_pkg::M0_IDLE) && m0_step && m0_clk_q &&
                   (m0_bit_q == 3'h7);
  assign m0_rx_start = (m0_st_q == spf_pkg::M0_IDLE) &&
                       (mode == spf_pkg::MODE_SHIFT) &&
                       rx_enable_q && !rx_done_flag_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      m0_st_q  <= spf_pkg::M0_IDLE;
      m0_sh_q  <= 8'h00;
      m0_cnt_q <= 8'h00;
      m0_bit_q <= 3'h0;
      m0_clk_q <= 1'b1;
    end else if (wr_sdata && mode == spf_pkg::MODE_SHIFT) begin
      m0_st_q  <= spf_pkg::M0_TX;
      m0_sh_q  <= wdata[7:0];
      m0_cnt_q <= 8'h00;
      m0_bit_q <= 3'h0;
      m0_clk_q <= 1'b0;
    end else if (m0_rx_start) begin
      m0_st_q  <= spf_pkg::M0_RX;
      m0_cnt_q <= 8'h00;
      m0_bit_q <= 3'h0;
      m0_clk_q <= 1'b0;
    end else if (m0_st_q != spf_pkg::M0_IDLE) begin
      if (!m0_step) begin
        m0_cnt_q <= m0_cnt_q + 8'h01;
      end else begin
        m0_cnt_q <= 8'h00;
        m0_clk_q <= ~m0_clk_q;
        if (!m0_clk_q && m0_st_q == spf_pkg::M0_RX) begin
          m0_sh_q <= {rxd_in, m0_sh_q[7:1]};
        end
        if (m0_clk_q && m0_st_q == spf_pkg::M0_TX) begin
          m0_sh_q <= {1'b0, m0_sh_q[7:1]};
        end
        if (m0_clk_q) begin
          m0_bit_q <= m0_bit_q + 3'h1;
        end
        if (m0_fin) begin
          m0_st_q  <= spf_pkg::M0_IDLE;
          m0_clk_q <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register and configuration
  logic tx_set, rx_set;

  assign tx_set = tx_fin || (m0_fin && m0_st_q == spf_pkg::M0_TX);
  assign rx_set = rx_load_async ||
                  (m0_fin && m0_st_q == spf_pkg::M0_RX);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_hi_q          <= spf_pkg::SCTL_RESET[spf_pkg::SC_MODE_HI];
      mode_lo_q          <= spf_pkg::SCTL_RESET[spf_pkg::SC_MODE_LO];
      multiproc_enable_q <= spf_pkg::SCTL_RESET[spf_pkg::SC_MP];
      rx_enable_q        <= spf_pkg::SCTL_RESET[spf_pkg::SC_REN];
      tx_ninth_bit_q     <= spf_pkg::SCTL_RESET[spf_pkg::SC_TB9];
    end else if (wr_sctl) begin
      if (!fes) begin
        mode_hi_q <= wdata[spf_pkg::SC_MODE_HI];
      end
      mode_lo_q          <= wdata[spf_pkg::SC_MODE_LO];
      multiproc_enable_q <= wdata[spf_pkg::SC_MP];
      rx_enable_q        <= wdata[spf_pkg::SC_REN];
      tx_ninth_bit_q     <= wdata[spf_pkg::SC_TB9];
    end
  end

  // Hardware set wins over a software write in the same cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tx_done_flag_q <= spf_pkg::SCTL_RESET[spf_pkg::SC_TI];
    end else if (tx_set) begin
      tx_done_flag_q <= 1'b1;
    end else if (wr_sctl) begin
      tx_done_flag_q <= wdata[spf_pkg::SC_TI];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rx_done_flag_q <= spf_pkg::SCTL_RESET[spf_pkg::SC_RI];
    end else if (rx_set) begin
      rx_done_flag_q <= 1'b1;
    end else if (wr_sctl) begin
      rx_done_flag_q <= wdata[spf_pkg::SC_RI];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      framing_error_flag_q <= 1'b0;
    end else if (ev_fe) begin
      framing_error_flag_q <= 1'b1;
    end else if (wr_sctl && fes) begin
      framing_error_flag_q <= wdata[spf_pkg::SC_MODE_HI];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rx_ninth_bit_q <= spf_pkg::SCTL_RESET[spf_pkg::SC_RB9];
      rx_hold_q      <= 8'h00;
    end else if (rx_load_async) begin
      rx_ninth_bit_q <= rx_ninth;
      rx_hold_q      <= rx_data;
    end else if (rx_set) begin
      rx_hold_q <= m0_sh_q;
    end else if (wr_sctl) begin
      rx_ninth_bit_q <= wdata[spf_pkg::SC_RB9];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cfg_q <= spf_pkg::CFG_RESET;
    end else if (wr_cfg) begin
      cfg_q <= wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read views, events and line roles
  assign sctl_rd  = {(fes ? framing_error_flag_q : mode_hi_q), mode_lo_q,
                     multiproc_enable_q, rx_enable_q, tx_ninth_bit_q,
                     rx_ninth_bit_q, tx_done_flag_q, rx_done_flag_q};
  assign sdata_rd = rx_hold_q;
  assign cfg_rd   = cfg_q;
  assign pin_swap_select = cfg_q[spf_pkg::CFG_SWAP];
  assign ev_tx    = tx_set;
  assign ev_rx    = rx_set;
  assign ev_fe    = rx_fin && !rxd_in;
  assign txr_out  = (mode == spf_pkg::MODE_SHIFT) ? m0_clk_q : tx_line_q;
  assign rxr_out  = m0_sh_q[0];
  assign rxr_oe_n = (m0_st_q != spf_pkg::M0_TX);

endmodule : spf_port

module spf_top #(
  parameter int NUM_PORTS = 2
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  // APB slave
  input  wire logic [7:0]           paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Interrupt
  output logic                      irq,
  // Serial pins, one bit per port
  input  wire logic [NUM_PORTS-1:0] pin_tx_in,
  output logic      [NUM_PORTS-1:0] pin_tx_out,
  output logic      [NUM_PORTS-1:0] pin_tx_oe_n,
  input  wire logic [NUM_PORTS-1:0] pin_rx_in,
  output logic      [NUM_PORTS-1:0] pin_rx_out,
  output logic      [NUM_PORTS-1:0] pin_rx_oe_n
);

  localparam int SW = spf_pkg::STAT_W * NUM_PORTS;

  logic [NUM_PORTS-1:0] wr_sctl, wr_sdata, wr_cfg, ev_tx, ev_rx, ev_fe;
  logic [7:0]  sctl_rd  [NUM_PORTS];
  logic [7:0]  sdata_rd [NUM_PORTS];
  logic [31:0] cfg_rd   [NUM_PORTS];
  logic [SW-1:0] irq_stat_q, irq_mask_q, ev_all;
  logic [31:0] rd_word;
  logic        hit, acc_done, wr_done;

  ////////////////////////////////////////////////////////////////////////////
  // APB: one wait state, answer registered
  assign acc_done = psel && penable && pready;
  assign wr_done  = acc_done && pwrite;

  always_comb begin
    rd_word  = 32'h0000_0000;
    hit      = 1'b0;
    wr_sctl  = '0;
    wr_sdata = '0;
    wr_cfg   = '0;
    if (paddr == spf_pkg::ADDR_IRQ_STAT) begin
      hit     = 1'b1;
      rd_word = 32'(irq_stat_q);
    end
    if (paddr == spf_pkg::ADDR_IRQ_MASK) begin
      hit     = 1'b1;
      rd_word = 32'(irq_mask_q);
    end
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (paddr == 8'(spf_pkg::ADDR_SCTL + i * spf_pkg::PORT_STRIDE)) begin
        hit        = 1'b1;
        rd_word    = 32'(sctl_rd[i]);
        wr_sctl[i] = wr_done;
      end
      if (paddr == 8'(spf_pkg::ADDR_SDATA + i * spf_pkg::PORT_STRIDE)) begin
        hit         = 1'b1;
        rd_word     = 32'(sdata_rd[i]);
        wr_sdata[i] = wr_done;
      end
      if (paddr == 8'(spf_pkg::ADDR_CFG + i * spf_pkg::PORT_STRIDE)) begin
        hit       = 1'b1;
        rd_word   = cfg_rd[i];
        wr_cfg[i] = wr_done;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_word;
        pslverr <= !hit;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: only bits already returned by the read are cleared
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_stat_q <= '0;
    end else if (acc_done && !pwrite && paddr == spf_pkg::ADDR_IRQ_STAT) begin
      irq_stat_q <= (irq_stat_q & ~prdata[SW-1:0]) | ev_all;
    end else begin
      irq_stat_q <= irq_stat_q | ev_all;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_mask_q <= '0;
    end else if (wr_done && paddr == spf_pkg::ADDR_IRQ_MASK) begin
      irq_mask_q <= pwdata[SW-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port instances with pin synchronisers and pin swap
  for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
    logic tx_meta_q, tx_sync_q, rx_meta_q, rx_sync_q;
    logic swap_sel, swapped, role_rx_in;
    logic txr_out, rxr_out, rxr_oe_n;

    always_ff @(posedge ref_clk) begin
      if (reset) begin
        tx_meta_q <= 1'b1;
        tx_sync_q <= 1'b1;
        rx_meta_q <= 1'b1;
        rx_sync_q <= 1'b1;
      end else begin
        tx_meta_q <= pin_tx_in[i];
        tx_sync_q <= tx_meta_q;
        rx_meta_q <= pin_rx_in[i];
        rx_sync_q <= rx_meta_q;
      end
    end

    assign swapped    = (i == 0) && swap_sel;
    assign role_rx_in = swapped ? tx_sync_q : rx_sync_q;

    assign ev_all[i*spf_pkg::STAT_W + spf_pkg::STAT_TX] = ev_tx[i];
    assign ev_all[i*spf_pkg::STAT_W + spf_pkg::STAT_RX] = ev_rx[i];
    assign ev_all[i*spf_pkg::STAT_W + spf_pkg::STAT_FE] = ev_fe[i];

    spf_port u_port (
      .ref_clk         (ref_clk),
      .reset           (reset),
      .wr_sctl         (wr_sctl[i]),
      .wr_sdata        (wr_sdata[i]),
      .wr_cfg          (wr_cfg[i]),
      .wdata           (pwdata),
      .sctl_rd         (sctl_rd[i]),
      .sdata_rd        (sdata_rd[i]),
      .cfg_rd          (cfg_rd[i]),
      .pin_swap_select (swap_sel),
      .rxd_in          (role_rx_in),
      .txr_out         (txr_out),
      .rxr_out         (rxr_out),
      .rxr_oe_n        (rxr_oe_n),
      .ev_tx           (ev_tx[i]),
      .ev_rx           (ev_rx[i]),
      .ev_fe           (ev_fe[i])
    );

    always_ff @(posedge ref_clk) begin
      if (reset) begin
        pin_tx_out[i]  <= 1'b1;
        pin_tx_oe_n[i] <= 1'b1;
        pin_rx_out[i]  <= 1'b1;
        pin_rx_oe_n[i] <= 1'b1;
      end else begin
        pin_tx_out[i]  <= swapped ? rxr_out : txr_out;
        pin_tx_oe_n[i] <= swapped ? rxr_oe_n : 1'b0;
        pin_rx_out[i]  <= swapped ? txr_out : rxr_out;
        pin_rx_oe_n[i] <= swapped ? 1'b0 : rxr_oe_n;
      end
    end
  end

endmodule : spf_top

// ---- spf_top_assertions.sv ----
// Bus, reset and pin checks on the serial port top
`timescale 1ns/1ns
module spf_top_chk #(
  parameter int NUM_PORTS = 2
) (
  // Clock and reset
  input wire logic                 ref_clk,
  input wire logic                 reset,
  // APB and interrupt
  input wire logic [7:0]           paddr,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 irq,
  // Pins
  input wire logic [NUM_PORTS-1:0] pin_tx_in,
  input wire logic [NUM_PORTS-1:0] pin_tx_out,
  input wire logic [NUM_PORTS-1:0] pin_tx_oe_n,
  input wire logic [NUM_PORTS-1:0] pin_rx_in,
  input wire logic [NUM_PORTS-1:0] pin_rx_out,
  input wire logic [NUM_PORTS-1:0] pin_rx_oe_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_rdy_one; pready |=> !pready; endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("pready long");
  property p_wait; psel && $rose(penable) |-> !pready ##1 pready; endproperty
  a_wait: assert property (p_wait) else $error("wait state wrong");
  property p_req; pready |-> psel && penable; endproperty
  a_req: assert property (p_req) else $error("pready unasked");
  property p_err; pready && pslverr |-> prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("error data set");
  property p_wr; pready && pwrite |-> prdata == 32'h0; endproperty
  a_wr: assert property (p_wr) else $error("write data set");
  property p_rst; $fell(reset) |-> !irq && !pready && &pin_rx_oe_n; endproperty
  a_rst: assert property (p_rst) else $error("reset outputs");
  property p_drv; $fell(reset) |=> !(|pin_tx_oe_n) && &pin_tx_out; endproperty
  a_drv: assert property (p_drv) else $error("tx pin idle");
  property p_fall; $fell(irq) |-> $past(pready) || $past(pready, 2); endproperty
  a_fall: assert property (p_fall) else $error("irq dropped");
endmodule : spf_top_chk

bind spf_top spf_top_chk #(.NUM_PORTS(NUM_PORTS)) chk_u (
  .ref_clk(ref_clk), .reset(reset), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq), .pin_tx_in(pin_tx_in),
  .pin_tx_out(pin_tx_out), .pin_tx_oe_n(pin_tx_oe_n),
  .pin_rx_in(pin_rx_in), .pin_rx_out(pin_rx_out), .pin_rx_oe_n(pin_rx_oe_n)
);

// ---- testbench.sv ----
// Self-checking bench for the serial port top
`timescale 1ns/1ns
module testbench;
  logic        ref_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, rem_rx, irq, pready, pslverr, got_v;
  logic [7:0]  paddr = '0, b, ad[3] = '{8'h5a, 8'hff, 8'h00};
  logic [8:0]  got;
  logic [31:0] pwdata = '0, prdata, rd_q[$], tx_q[$];
  logic [1:0]  tx_o, tx_oe, rx_o, rx_oe, tx_w, rx_w;
  int          error_cnt, n_compared;
  logic        err_q[$];
  // Released lines are pulled up, except the first port's receive line, which the remote drives
  assign tx_w = tx_oe | tx_o;
  assign rx_w = {rx_oe[1] | rx_o[1], rx_oe[0] ? rem_rx : rx_o[0]};
  spf_top dut_u (
    .ref_clk(ref_clk), .reset(reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .pin_tx_in(tx_w),
    .pin_tx_out(tx_o), .pin_tx_oe_n(tx_oe), .pin_rx_in(rx_w),
    .pin_rx_out(rx_o), .pin_rx_oe_n(rx_oe));
  // Bit time follows the reset divisor: 16 ticks of divisor plus one
  spf_remote #(.BIT(16 * (int'(spf_pkg::CFG_RESET[7:0]) + 1))) rem_u (
    .ref_clk(ref_clk), .tx_line(tx_w[0]),
    .rx_line(rem_rx), .got(got), .got_v(got_v));
  initial forever #20 ref_clk = ~ref_clk;
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    results();
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task results;
    if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    err_q.push_back(a == 8'h10);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // Port sends d while the remote sends d with stop bit s
  task frame(input logic [7:0] d, input logic s, input logic n = 1'b1);
    tx_q.push_back({23'h0, n, d});
    fork
      rem_u.send(d, s);
      apb(1'b1, spf_pkg::ADDR_SDATA, {24'h0, d});
    join
    repeat (240) @(posedge ref_clk);
  endtask : frame
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk("prdata", rd_q.pop_front(), prdata);
      chk("pslverr", {31'h0, err_q.pop_front()}, {31'h0, pslverr});
    end
    if (got_v === 1'b1) begin
      chk("tx_frame", tx_q.pop_front(), {23'h0, got});
    end
  end
  initial begin
    b = 8'($urandom(32685));
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    rd(spf_pkg::ADDR_SCTL, 32'h0);
    rd(spf_pkg::ADDR_CFG, spf_pkg::CFG_RESET);
    rd(8'h10, 32'h0);
    apb(1'b1, spf_pkg::ADDR_IRQ_MASK, 32'h7);
    apb(1'b1, spf_pkg::ADDR_SCTL, 32'h50);
    frame(b, 1'b1);
    chk("irq", 32'h1, {31'h0, irq});
    rd(spf_pkg::ADDR_SDATA, {24'h0, b});
    rd(spf_pkg::ADDR_SCTL, 32'h57);
    rd(spf_pkg::ADDR_IRQ_STAT, 32'h3);
    rd(spf_pkg::ADDR_IRQ_STAT, 32'h0);
    repeat (3) @(posedge ref_clk);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, spf_pkg::ADDR_CFG, 32'h01ff000c);
    apb(1'b1, spf_pkg::ADDR_SCTL, 32'h50);
    b = 8'($urandom());
    frame(b, 1'b0);
    rd(spf_pkg::ADDR_IRQ_STAT, 32'h7);
    rd(spf_pkg::ADDR_SCTL, 32'hd3);
    apb(1'b1, spf_pkg::ADDR_SCTL, 32'h70);
    rd(spf_pkg::ADDR_SCTL, 32'h70);
    for (int i = 0; i < 3; i++) begin
      rem_u.send(ad[i], 1'b1);
      repeat (8) @(posedge ref_clk);
      rd(spf_pkg::ADDR_IRQ_STAT, {30'h0, ad[i] != 8'h5a, 1'b0});
      apb(1'b1, spf_pkg::ADDR_SCTL, 32'h70);
    end
    apb(1'b1, spf_pkg::ADDR_CFG, spf_pkg::CFG_RESET);
    apb(1'b1, spf_pkg::ADDR_SCTL, 32'hd0);
    b = 8'($urandom());
    frame(b, 1'b1, 1'b0);
    rd(spf_pkg::ADDR_SDATA, {24'h0, b});
    rd(spf_pkg::ADDR_SCTL, 32'hd7);
    results();
  end
endmodule : testbench
